// [bench/test_peripheral_pin_remap.sv]
// Self-checking bench for the pin remap block, large variant.
// Assumes an Avalon-MM slave with waitrequest on sys_clk; a small-variant copy shares the bus.
`timescale 1ns/1ps
`include "pin_remap_cfg.svh"
module test_peripheral_pin_remap import pin_remap_pkg::*;;
	// Bench-driven inputs
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hF;
	logic [7:0] pin_in = 8'h00;
	logic pirq = 1'b0;
	logic pclk = 1'b0;
	logic cha = 1'b0;
	logic [2:0] chb = 3'h0;
	logic [1:0] ta = 2'h0;
	logic [1:0] tc = 2'h0;
	// Design outputs
	logic [31:0] readdata;
	logic [31:0] rd_small;
	logic waitrequest;
	logic [4:0] routed;
	logic [7:0] pb_out, pb_oe, pc_out, pc_oe, pe_out, pe_oe;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	peripheral_pin_remap #(.LARGE_VARIANT(1'b1)) dut
	(
		.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.pin_in(pin_in), .ext_irq_b(routed[4]), .ext_irq_a(routed[3]), .timer_b_clkin(routed[2]),
		.timer_a_clkin(routed[1]), .timer_c_clkin(routed[0]), .periph_irq_signal(pirq),
		.periph_clk_signal(pclk), .timer_b_cha_out(cha), .timer_b_chb_out(chb), .timer_a_out(ta),
		.timer_c_out(tc), .pb_out(pb_out), .pb_oe(pb_oe), .pc_out(pc_out), .pc_oe(pc_oe),
		.pe_out(pe_out), .pe_oe(pe_oe)
	);

	// Small variant on the same bus; only its read data is watched
	peripheral_pin_remap #(.LARGE_VARIANT(1'b0)) dut_small
	(
		.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(rd_small), .waitrequest(),
		.pin_in(pin_in), .ext_irq_b(), .ext_irq_a(), .timer_b_clkin(), .timer_a_clkin(), .timer_c_clkin(),
		.periph_irq_signal(pirq), .periph_clk_signal(pclk), .timer_b_cha_out(cha), .timer_b_chb_out(chb),
		.timer_a_out(ta), .timer_c_out(tc), .pb_out(), .pb_oe(), .pc_out(), .pc_oe(), .pe_out(), .pe_oe()
	);

	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge; data taken at that edge
	task automatic bus_access(input logic [3:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk);
		address <= a;
		writedata <= {24'h0, d};
		read <= ~wr;
		write <= wr;
		@(posedge sys_clk);
		while (waitrequest)
			@(posedge sys_clk);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus_access(a, 1'b1, d, q);
	endtask

	task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] q;
		bus_access(a, 1'b0, 8'h00, q);
		check({24'h0, q}, {24'h0, exp});
	endtask

	task automatic test_reset();
		rd_check(`REMAP_OFS_ONE, `REMAP_RST);
		rd_check(`REMAP_OFS_TWO, `REMAP_RST);
		rd_check(`REMAP_OFS_SEG, `REMAP_RST);
	endtask

	// Read-back, masked bits, unmapped and disabled-lane writes
	task automatic test_regs();
		wr(`REMAP_OFS_ONE, 8'h5A);
		rd_check(`REMAP_OFS_ONE, 8'h5A);
		byteenable <= 4'h0;
		wr(`REMAP_OFS_ONE, 8'hA5);
		byteenable <= 4'hF;
		rd_check(`REMAP_OFS_ONE, 8'h5A);
		wr(`REMAP_OFS_TWO, 8'hFF);
		rd_check(`REMAP_OFS_TWO, 8'hFF);
		check(rd_small, 32'h000000F3);
		wr(`REMAP_OFS_SEG, 8'hFF);
		rd_check(`REMAP_OFS_SEG, 8'h80);
		rd_check(4'h2, 8'h00);
		wr(`REMAP_OFS_VARIANT, 8'h00);
		rd_check(`REMAP_OFS_VARIANT, 8'h01);
		check(rd_small, 32'h00000000);
		wr(`REMAP_OFS_ONE, 8'h00);
		wr(`REMAP_OFS_TWO, 8'h00);
	endtask

	// Inputs: exp is {irq_b, irq_a, clk_b, clk_a, clk_c}
	task automatic in_case(input logic [7:0] c1, input logic [7:0] seg, input logic [7:0] p, input logic [4:0] exp);
		wr(`REMAP_OFS_ONE, c1);
		wr(`REMAP_OFS_SEG, seg);
		pin_in <= p;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		check({27'h0, routed}, {27'h0, exp});
	endtask

	task automatic test_inputs();
		in_case(8'h00, 8'h00, 8'h80, 5'b10100);
		in_case(8'h00, 8'h00, 8'h40, 5'b01010);
		in_case(8'h00, 8'h00, 8'h08, 5'b00001);
		in_case(8'hF0, 8'h00, 8'h20, 5'b10100);
		in_case(8'hF0, 8'h00, 8'h10, 5'b01010);
		in_case(8'hF0, 8'h00, 8'hC0, 5'b00000);
		in_case(8'h00, 8'h80, 8'h04, 5'b00001);
		in_case(8'h00, 8'h80, 8'h08, 5'b00000);
	endtask

	// Outputs: exp is {pb_oe, pc_oe, pe_oe} with every source high
	task automatic out_case(input logic [7:0] c1, input logic [7:0] c2, input logic [23:0] exp);
		wr(`REMAP_OFS_ONE, c1);
		wr(`REMAP_OFS_TWO, c2);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check({8'h0, pb_oe, pc_oe, pe_oe}, {8'h0, exp});
		check({8'h0, pb_out, pc_out, pe_out} & {8'h0, exp}, {8'h0, exp});
	endtask

	task automatic test_outputs();
		pirq <= 1'b1;
		pclk <= 1'b1;
		cha <= 1'b1;
		chb <= 3'h7;
		ta <= 2'h3;
		tc <= 2'h3;
		out_case(8'h00, 8'h00, 24'h3F0000);
		out_case(8'h00, 8'hFF, 24'h303F06);
		out_case(8'h05, 8'hFF, 24'h00FF06);
		out_case(8'h0A, 8'hFF, 24'h003F07);
		out_case(8'h0F, 8'hFF, 24'h003F06);
		ta <= 2'h1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		check({30'h0, pc_out[1:0]}, 32'h1);
	endtask

	// Mid-run reset clears every field and every pin enable
	task automatic test_reset_again();
		wr(`REMAP_OFS_ONE, 8'hFF);
		wr(`REMAP_OFS_TWO, 8'hFF);
		wr(`REMAP_OFS_SEG, 8'h80);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check({8'h0, pb_oe, pc_oe, pe_oe}, 32'h00000000);
		test_reset();
	endtask

	// Main sequence
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		test_reset();
		test_regs();
		test_inputs();
		test_outputs();
		test_reset_again();
		stop_test();
	end
endmodule // test_peripheral_pin_remap

// [core/peripheral_pin_remap.sv]
// Pin remap selector: registers route peripheral signals to port pins.
// Assumes an Avalon-MM master on sys_clk and port pins asynchronous to it.
`timescale 1ns/1ps
`include "pin_remap_cfg.svh"
module peripheral_pin_remap
	import pin_remap_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Raw pin inputs {PA1,PA4,PC5,PC4,PC6,PD0,0,0}
	input wire logic [7:0] pin_in,
	// Routed inputs to peripherals
	output logic ext_irq_b,
	output logic ext_irq_a,
	output logic timer_b_clkin,
	output logic timer_a_clkin,
	output logic timer_c_clkin,
	// Peripheral outputs to be placed
	input wire logic periph_irq_signal,
	input wire logic periph_clk_signal,
	input wire logic timer_b_cha_out,
	input wire logic [2:0] timer_b_chb_out,
	input wire logic [1:0] timer_a_out,
	input wire logic [1:0] timer_c_out,
	// Pin override: value and enable per port, bit n is pin n
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe,
	output logic [7:0] pe_out,
	output logic [7:0] pe_oe
);
	logic [7:0] pin_remap_ctrl_one;
	logic [7:0] pin_remap_ctrl_two;
	logic [7:0] segment_ctrl_three;
	logic [7:0] pin_s;
	logic acc_done;
	logic [7:0] next_pb_out, next_pb_oe, next_pc_out, next_pc_oe, next_pe_out, next_pe_oe;
	tri_sel_t periph_irq_pin_sel;
	tri_sel_t periph_clk_pin_sel;

	// Two-way choice of a sampled pin
	function automatic logic pick(input logic sel, input logic pin0, input logic pin1);
		return sel ? pin1 : pin0;
	endfunction

	// Pin inputs are asynchronous, so synchronise before selection
	pin_sync u_sync
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.din(pin_in),
		.dout(pin_s)
	);

	// One wait cycle per access; answer the cycle after the request appears
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			acc_done <= 1'b0;
		else
			acc_done <= (read | write) & ~acc_done;
	end
	assign waitrequest = (read | write) & ~acc_done;

	// Register writes, low byte lane only; other offsets ignore writes
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_remap_ctrl_one <= `REMAP_RST;
			pin_remap_ctrl_two <= `REMAP_RST;
			segment_ctrl_three <= `REMAP_RST;
		end
		else if (write && !waitrequest && byteenable[0])
		begin
			unique case (address)
				`REMAP_OFS_ONE: pin_remap_ctrl_one <= writedata[7:0];
				`REMAP_OFS_TWO: pin_remap_ctrl_two <= writedata[7:0] &
					(LARGE_VARIANT ? `F2_LARGE_MASK : `F2_SMALL_MASK);
				`REMAP_OFS_SEG: segment_ctrl_three <= writedata[7:0] & `F3_MASK;
				default: ;
			endcase
		end
	end

	// Read data, registered; unmapped offsets read zero
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			readdata <= 32'h00000000;
		else if (read && waitrequest)
		begin
			unique case (address)
				`REMAP_OFS_ONE: readdata <= {24'h000000, pin_remap_ctrl_one};
				`REMAP_OFS_TWO: readdata <= {24'h000000, pin_remap_ctrl_two};
				`REMAP_OFS_SEG: readdata <= {24'h000000, segment_ctrl_three};
				`REMAP_OFS_VARIANT: readdata <= {31'h00000000, LARGE_VARIANT};
				default: readdata <= 32'h00000000;
			endcase
		end
	end

	// Selector fields; the small variant has only the low bit of each pair
	assign periph_irq_pin_sel = tri_sel_t'({LARGE_VARIANT & pin_remap_ctrl_one[`F1_PIRQ_HI],
		pin_remap_ctrl_one[`F1_PIRQ_LO]});
	assign periph_clk_pin_sel = tri_sel_t'({LARGE_VARIANT & pin_remap_ctrl_one[`F1_PCLK_HI],
		pin_remap_ctrl_one[`F1_PCLK_LO]});

	// Input routing; pins 7..2 of pin_s are PA1,PA4,PC5,PC4,PC6,PD0
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ext_irq_b <= 1'b0;
			ext_irq_a <= 1'b0;
			timer_b_clkin <= 1'b0;
			timer_a_clkin <= 1'b0;
			timer_c_clkin <= 1'b0;
		end
		else
		begin
			ext_irq_b <= pick(pin_remap_ctrl_one[`F1_EXT_IRQ_B], pin_s[7], pin_s[5]);
			ext_irq_a <= pick(pin_remap_ctrl_one[`F1_EXT_IRQ_A], pin_s[6], pin_s[4]);
			timer_b_clkin <= pick(pin_remap_ctrl_one[`F1_TIMER_B_CLK], pin_s[7], pin_s[5]);
			timer_a_clkin <= pick(pin_remap_ctrl_one[`F1_TIMER_A_CLK], pin_s[6], pin_s[4]);
			// Small variant has no timer c; hold it low
			timer_c_clkin <= LARGE_VARIANT &
				pick(segment_ctrl_three[`F3_TIMER_C_CLK], pin_s[3], pin_s[2]);
		end
	end

	// Output placement: only the selected pin is enabled
	always_comb
	begin
		next_pb_out = 8'h00;
		next_pb_oe = 8'h00;
		next_pc_out = 8'h00;
		next_pc_oe = 8'h00;
		next_pe_out = 8'h00;
		next_pe_oe = 8'h00;
		// Undefined code 11 drives nothing, the safe reading
		unique case (periph_irq_pin_sel)
			SEL_PB: begin next_pb_out[5] = periph_irq_signal; next_pb_oe[5] = 1'b1; end
			SEL_PC: begin next_pc_out[7] = periph_irq_signal; next_pc_oe[7] = 1'b1; end
			SEL_PE: begin next_pe_out[0] = periph_irq_signal; next_pe_oe[0] = 1'b1; end
			SEL_UNDEF: ;
		endcase
		unique case (periph_clk_pin_sel)
			SEL_PB: begin next_pb_out[4] = periph_clk_signal; next_pb_oe[4] = 1'b1; end
			SEL_PC: begin next_pc_out[6] = periph_clk_signal; next_pc_oe[6] = 1'b1; end
			SEL_PE: begin next_pe_out[1] = periph_clk_signal; next_pe_oe[1] = 1'b1; end
			SEL_UNDEF: ;
		endcase
		// Timer b channel b: bit 5+k moves PBk+2 to PCk+2
		for (int k = 0; k < 3; k++)
		begin
			if (pin_remap_ctrl_two[`F2_CHB0 + k])
			begin
				next_pc_out[k + 2] = timer_b_chb_out[k];
				next_pc_oe[k + 2] = 1'b1;
			end
			else
			begin
				next_pb_out[k + 2] = timer_b_chb_out[k];
				next_pb_oe[k + 2] = 1'b1;
			end
		end
		if (pin_remap_ctrl_two[`F2_CHA])
		begin
			next_pc_out[5] = timer_b_cha_out;
			next_pc_oe[5] = 1'b1;
		end
		else
		begin
			next_pb_out[5] = timer_b_cha_out;
			next_pb_oe[5] = 1'b1;
		end
		// Timer a outputs on PB1..0 or PC1..0
		for (int k = 0; k < 2; k++)
		begin
			if (pin_remap_ctrl_two[`F2_A_OUT0 + k])
			begin
				next_pc_out[k] = timer_a_out[k];
				next_pc_oe[k] = 1'b1;
			end
			else
			begin
				next_pb_out[k] = timer_a_out[k];
				next_pb_oe[k] = 1'b1;
			end
		end
		// Timer c exists only on the large variant; PB and PE pins may be shared
		if (LARGE_VARIANT)
		begin
			for (int k = 0; k < 2; k++)
			begin
				if (pin_remap_ctrl_two[`F2_C_OUT0 + k])
				begin
					next_pe_out[k + 1] = timer_c_out[k];
					next_pe_oe[k + 1] = 1'b1;
				end
				else
				begin
					next_pb_out[k + 1] = timer_c_out[k];
					next_pb_oe[k + 1] = 1'b1;
				end
			end
		end
	end

	// Pin outputs registered for clean edges
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pb_out <= 8'h00;
			pb_oe <= 8'h00;
			pc_out <= 8'h00;
			pc_oe <= 8'h00;
			pe_out <= 8'h00;
			pe_oe <= 8'h00;
		end
		else
		begin
			pb_out <= next_pb_out;
			pb_oe <= next_pb_oe;
			pc_out <= next_pc_out;
			pc_oe <= next_pc_oe;
			pe_out <= next_pe_out;
			pe_oe <= next_pe_oe;
		end
	end

	// Checks
	chk_ext_irq_b: assert property (@(posedge sys_clk) disable iff (rst)
		##1 ext_irq_b == ($past(pin_remap_ctrl_one[7]) ? $past(pin_s[5]) : $past(pin_s[7])))
		else $error("ext_irq_b source wrong");
	chk_ext_irq_a: assert property (@(posedge sys_clk) disable iff (rst)
		##1 ext_irq_a == ($past(pin_remap_ctrl_one[6]) ? $past(pin_s[4]) : $past(pin_s[6])))
		else $error("ext_irq_a source wrong");
	chk_timer_b_clk: assert property (@(posedge sys_clk) disable iff (rst)
		##1 timer_b_clkin == ($past(pin_remap_ctrl_one[5]) ? $past(pin_s[5]) : $past(pin_s[7])))
		else $error("timer b clock source wrong");
	chk_timer_a_clk: assert property (@(posedge sys_clk) disable iff (rst)
		##1 timer_a_clkin == ($past(pin_remap_ctrl_one[4]) ? $past(pin_s[4]) : $past(pin_s[6])))
		else $error("timer a clock source wrong");
	chk_pirq_pe: assert property (@(posedge sys_clk) disable iff (rst)
		periph_irq_pin_sel == SEL_PE |=> pe_oe[0] && pe_out[0] == $past(periph_irq_signal))
		else $error("peripheral irq not on PE0");
	chk_pclk_pc: assert property (@(posedge sys_clk) disable iff (rst)
		periph_clk_pin_sel == SEL_PC |=> pc_oe[6] && pc_out[6] == $past(periph_clk_signal))
		else $error("peripheral clock not on PC6");
	chk_chb2_pin: assert property (@(posedge sys_clk) disable iff (rst)
		pin_remap_ctrl_two[7] |=> pc_oe[4] && pc_out[4] == $past(timer_b_chb_out[2]))
		else $error("timer b chb2 not on PC4");
	chk_cha_pin: assert property (@(posedge sys_clk) disable iff (rst)
		!pin_remap_ctrl_two[4] |=> pb_oe[5] && !pc_oe[5])
		else $error("timer b cha not on PB5");
	chk_small_zero: assert property (@(posedge sys_clk) disable iff (rst)
		!LARGE_VARIANT |-> pin_remap_ctrl_two[3:2] == 2'b00)
		else $error("unimplemented bits set");
	chk_seg_zero: assert property (@(posedge sys_clk) disable iff (rst)
		segment_ctrl_three[6:0] == 7'h00)
		else $error("segment low bits set");
	chk_irq_undef: assert property (@(posedge sys_clk) disable iff (rst)
		periph_irq_pin_sel == SEL_UNDEF |=> !pc_oe[7] && !pe_oe[0])
		else $error("peripheral irq driven on undefined code");
	chk_pclk_pb: assert property (@(posedge sys_clk) disable iff (rst)
		periph_clk_pin_sel == SEL_PB |=> pb_oe[4] && !pc_oe[6])
		else $error("peripheral clock not on PB4");
	// No disable here: this one watches the reset itself
	chk_reset_clear: assert property (@(posedge sys_clk)
		rst |=> pin_remap_ctrl_one == `REMAP_RST && pin_remap_ctrl_two == `REMAP_RST &&
		segment_ctrl_three == `REMAP_RST)
		else $error("remap fields not cleared by reset");
	cov_pirq_pc: cover property (@(posedge sys_clk) disable iff (rst) periph_irq_pin_sel == SEL_PC);
	cov_write_two: cover property (@(posedge sys_clk) disable iff (rst)
		write && !waitrequest && address == `REMAP_OFS_TWO);
	cov_tc_pd0: cover property (@(posedge sys_clk) disable iff (rst) segment_ctrl_three[7]);
	cov_pirq_undef: cover property (@(posedge sys_clk) disable iff (rst) periph_irq_pin_sel == SEL_UNDEF);
endmodule // peripheral_pin_remap

// [core/pin_remap_cfg.svh]
// Register offsets, field positions and reset values of the pin remap block.
// Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
`ifndef PIN_REMAP_CFG_SVH
`define PIN_REMAP_CFG_SVH
`define REMAP_OFS_ONE 4'h0
`define REMAP_OFS_TWO 4'h4
`define REMAP_OFS_SEG 4'h8
`define REMAP_OFS_VARIANT 4'hC
`define REMAP_RST 8'h00
`define F1_EXT_IRQ_B 7
`define F1_EXT_IRQ_A 6
`define F1_TIMER_B_CLK 5
`define F1_TIMER_A_CLK 4
`define F1_PIRQ_HI 3
`define F1_PIRQ_LO 2
`define F1_PCLK_HI 1
`define F1_PCLK_LO 0
`define F2_CHB2 7
`define F2_CHB1 6
`define F2_CHB0 5
`define F2_CHA 4
`define F2_C_OUT1 3
`define F2_C_OUT0 2
`define F2_A_OUT1 1
`define F2_A_OUT0 0
`define F3_TIMER_C_CLK 7
`define F2_LARGE_MASK 8'hFF
`define F2_SMALL_MASK 8'hF3
`define F3_MASK 8'h80
`endif

// [core/pin_remap_pkg.sv]
// Types shared by the pin remap block.
// Assumes nothing beyond the cfg header.
package pin_remap_pkg;
	// Three-way pin choice of a two-bit selector
	typedef enum logic [1:0] {SEL_PB, SEL_PC, SEL_PE, SEL_UNDEF} tri_sel_t;
endpackage

// [core/pin_sync.sv]
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ps
module pin_sync
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Data
	input wire logic [7:0] din,
	output logic [7:0] dout
);
	logic [7:0] meta;

	// First stage feeds only the second
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			meta <= 8'h00;
			dout <= 8'h00;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // pin_sync
